//--- mac_block.sv
// Configurable multiply-accumulate block with lane splitting and right shift.
// Assumes operands from fabric logic on ref_clk_i; mode and signedness static.
//
// Contract
// - Normal: one 19x18 product, 48-bit add/sub.
// - Dual: 11x10 and 8x8, two 24-bit adders.
// - Quad: 7x6 and three 4x4, 12-bit adders.
// - Quad 7x6 lane output truncated to 12 bits.
// - Float: unrounded BFLOAT16 fused multiply-add.
// - 4-bit right shift on one, two, four lanes.
// - One signedness choice for all packed functions.
// - Product from A and B, optionally into adder.
// - Add, subtract or accumulate across cycles.
`timescale 1ns/1ns
module mac_block
#(
   parameter mac_pkg::mode_e MODE = mac_pkg::MODE_NORMAL,
   parameter bit SIGNED = 1'b1
)
(
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Operands from fabric.
   input wire logic valid_i,
   input wire mac_pkg::operands_s opnd_i,
   // Result to fabric.
   output logic valid_o,
   output logic [mac_pkg::ACC_W-1:0] result_o
);

   // Multiply with the one static signedness choice.
   // shared signedness
   function automatic logic [47:0] mul(input logic [18:0] x, input logic [17:0] y,
                                       input int xw, input int yw);
      logic signed [47:0] xs;
      logic signed [47:0] ys;
      xs = 48'(x);
      ys = 48'(y);
      if (SIGNED)
      begin
         xs = (xs <<< (48 - xw)) >>> (48 - xw);
         ys = (ys <<< (48 - yw)) >>> (48 - yw);
      end
      return 48'(xs * ys);
   endfunction : mul

   // Shift right, arithmetic when signed.
   function automatic logic [47:0] shr(input logic [47:0] v, input int w, input logic [3:0] s);
      logic signed [47:0] t;
      t = signed'(v << (48 - w));
      t = SIGNED ? (t >>> s) : signed'(48'(v << (48 - w)) >> s);
      return 48'(t) >> (48 - w);
   endfunction : shr

   // Lane combine: product, add, subtract or accumulate.
   function automatic logic [47:0] arith(input mac_pkg::op_e op, input logic [47:0] p,
                                         input logic [47:0] c, input logic [47:0] acc);
      case (op)
         mac_pkg::OP_ADD: return p + c;
         mac_pkg::OP_SUB: return c - p;
         mac_pkg::OP_ACC: return acc + p;
         default: return p;
      endcase
   endfunction : arith

   // Result state and the operand fields that every lane slices.
   logic [mac_pkg::ACC_W-1:0] result_q;
   logic [mac_pkg::ACC_W-1:0] result_d;
   logic valid_q;
   wire logic [18:0] a = opnd_i.a;
   wire logic [17:0] b = opnd_i.b;
   wire logic [47:0] c = opnd_i.c;
   wire logic [3:0] sh = opnd_i.shift;

   wire logic [47:0] n_p = mul(a, b, mac_pkg::A_W, mac_pkg::B_W);
   wire logic [47:0] n_s = arith(opnd_i.op, n_p, c, result_q);
   wire logic [47:0] n_r = shr(n_s, mac_pkg::ACC_W, sh);

   wire logic [47:0] d0_p = mul(19'(a[10:0]), 18'(b[9:0]), mac_pkg::D0A_W, mac_pkg::D0B_W);
   wire logic [47:0] d1_p = mul(19'(a[18:11]), 18'(b[17:10]), mac_pkg::D1_W, mac_pkg::D1_W);
   wire logic [47:0] d0_s = arith(opnd_i.op, d0_p, 48'(c[23:0]), 48'(result_q[23:0]));
   wire logic [47:0] d1_s = arith(opnd_i.op, d1_p, 48'(c[47:24]), 48'(result_q[47:24]));
   wire logic [23:0] d0_r = 24'(shr(d0_s, mac_pkg::DUAL_W, sh));
   wire logic [23:0] d1_r = 24'(shr(d1_s, mac_pkg::DUAL_W, sh));

   wire logic [47:0] q0_p = mul(19'(a[6:0]), 18'(b[5:0]), mac_pkg::Q0A_W, mac_pkg::Q0B_W);
   wire logic [47:0] q1_p = mul(19'(a[10:7]), 18'(b[9:6]), mac_pkg::Q1_W, mac_pkg::Q1_W);
   wire logic [47:0] q2_p = mul(19'(a[14:11]), 18'(b[13:10]), mac_pkg::Q1_W, mac_pkg::Q1_W);
   wire logic [47:0] q3_p = mul(19'(a[18:15]), 18'(b[17:14]), mac_pkg::Q1_W, mac_pkg::Q1_W);
   wire logic [47:0] q0_t = 48'(q0_p[11:0]);
   wire logic [47:0] q0_s = arith(opnd_i.op, q0_t, 48'(c[11:0]), 48'(result_q[11:0]));
   wire logic [47:0] q1_s = arith(opnd_i.op, q1_p, 48'(c[23:12]), 48'(result_q[23:12]));
   wire logic [47:0] q2_s = arith(opnd_i.op, q2_p, 48'(c[35:24]), 48'(result_q[35:24]));
   wire logic [47:0] q3_s = arith(opnd_i.op, q3_p, 48'(c[47:36]), 48'(result_q[47:36]));
   wire logic [47:0] q_r = {12'(shr(q3_s, mac_pkg::QUAD_W, sh)),
                            12'(shr(q2_s, mac_pkg::QUAD_W, sh)),
                            12'(shr(q1_s, mac_pkg::QUAD_W, sh)),
                            12'(shr(q0_s, mac_pkg::QUAD_W, sh))};

   // Float lane: addend from c, or from the stored result when accumulating.
   // fused float lane
   wire logic [15:0] f_acc = (opnd_i.op == mac_pkg::OP_ACC) ? result_q[15:0] : c[15:0];
   wire logic [15:0] f_y;
   bf16_fma u_fma
   (
      .a_i(a[15:0]),
      .b_i(b[15:0]),
      .acc_i((opnd_i.op == mac_pkg::OP_PRODUCT) ? 16'h0000 : f_acc),
      .sub_i(opnd_i.op == mac_pkg::OP_SUB),
      .y_o(f_y)
   );

   always_comb
   begin
      case (MODE)
         mac_pkg::MODE_NORMAL: result_d = n_r;
         mac_pkg::MODE_DUAL: result_d = {d1_r, d0_r};
         mac_pkg::MODE_QUAD: result_d = q_r;
         mac_pkg::MODE_FLOAT: result_d = {32'h0000_0000, f_y};
         default: result_d = n_r;
      endcase
   end

   // Result register; holds between valid operands so accumulation spans cycles.
   // accumulate register
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         result_q <= 48'h0;
         valid_q <= 1'b0;
      end
      else
      begin
         valid_q <= valid_i;
         if (valid_i)
         begin
            result_q <= result_d;
         end
      end
   end

   assign result_o = result_q;
   assign valid_o = valid_q;

   // Assertions.
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   // Operand qualifiers shared by the checks below.
   wire logic plain_take = valid_i && opnd_i.op == mac_pkg::OP_PRODUCT && sh == 4'h0;
   wire logic unshifted_take = valid_i && sh == 4'h0;

   // Handshake: exactly one answer per taken operand, none otherwise.
   a_valid_one_cycle: assert property (valid_i |=> valid_o)
      else $error("valid did not follow operand");
   a_valid_drop: assert property (!valid_i |=> !valid_o)
      else $error("valid rose without operand");
   a_result_hold: assert property (!valid_i |=> $stable(result_o))
      else $error("result changed without operand");

   // Normal lane: product, add, subtract and accumulate without shift.
   a_normal_product: assert property (MODE == mac_pkg::MODE_NORMAL && plain_take
      |=> result_o == $past(n_p))
      else $error("normal product wrong");
   a_normal_add: assert property (MODE == mac_pkg::MODE_NORMAL && unshifted_take
      && opnd_i.op == mac_pkg::OP_ADD |=> result_o == 48'($past(c) + $past(n_p)))
      else $error("normal add wrong");
   a_normal_sub: assert property (MODE == mac_pkg::MODE_NORMAL && unshifted_take
      && opnd_i.op == mac_pkg::OP_SUB |=> result_o == 48'($past(c) - $past(n_p)))
      else $error("normal subtract wrong");
   a_acc_sums: assert property (MODE == mac_pkg::MODE_NORMAL && unshifted_take
      && opnd_i.op == mac_pkg::OP_ACC
      |=> result_o == 48'($past(result_o) + $past(n_p)))
      else $error("accumulate wrong");

   // Split lanes: each plain product lands in its own result field.
   a_dual_split: assert property (MODE == mac_pkg::MODE_DUAL && plain_take
      |=> result_o[23:0] == $past(d0_p[23:0]))
      else $error("dual lane wrong");
   a_dual_lane1: assert property (MODE == mac_pkg::MODE_DUAL && plain_take
      |=> result_o[47:24] == $past(d1_p[23:0]))
      else $error("dual lane one wrong");
   a_quad_trunc: assert property (MODE == mac_pkg::MODE_QUAD && plain_take
      |=> result_o[11:0] == $past(q0_p[11:0]))
      else $error("quad lane not truncated");
   a_quad_lane1: assert property (MODE == mac_pkg::MODE_QUAD && plain_take
      |=> result_o[23:12] == $past(q1_p[11:0]))
      else $error("quad lane one wrong");
   a_quad_lane2: assert property (MODE == mac_pkg::MODE_QUAD && plain_take
      |=> result_o[35:24] == $past(q2_p[11:0]))
      else $error("quad lane two wrong");
   a_quad_lane3: assert property (MODE == mac_pkg::MODE_QUAD && plain_take
      |=> result_o[47:36] == $past(q3_p[11:0]))
      else $error("quad lane three wrong");

   // Float lane and the shared right shift, arithmetic when signed.
   a_float_upper: assert property (MODE == mac_pkg::MODE_FLOAT && valid_i
      |=> result_o[47:16] == 32'h0)
      else $error("float upper bits set");
   a_shift_normal: assert property (MODE == mac_pkg::MODE_NORMAL && valid_i
      |=> result_o == (SIGNED ? 48'($signed($past(n_s)) >>> $past(sh))
                              : 48'($past(n_s) >> $past(sh))))
      else $error("shift wrong");

   // Coverage of the main scenarios.
   c_accumulate: cover property (valid_i && opnd_i.op == mac_pkg::OP_ACC ##1 valid_i
      && opnd_i.op == mac_pkg::OP_ACC);
   c_subtract: cover property (valid_i && opnd_i.op == mac_pkg::OP_SUB);
   c_shifted: cover property (valid_i && sh != 4'h0);
   c_back_to_back: cover property (valid_i ##1 valid_i);
   c_float_acc: cover property (MODE == mac_pkg::MODE_FLOAT && valid_i
      && opnd_i.op == mac_pkg::OP_ACC);

endmodule : mac_block

//--- mac_pkg.sv
// Package for the multiply-accumulate block: modes, widths and operand carriers.
// Assumes one fabric clock and an active-low asynchronous reset at the multiply-accumulate block.
package mac_pkg;

   // Operating modes, fixed by configuration.
   typedef enum logic [1:0]
   {
      MODE_NORMAL = 2'h0,
      MODE_DUAL = 2'h1,
      MODE_QUAD = 2'h2,
      MODE_FLOAT = 2'h3
   } mode_e;

   // Arithmetic stage operation.
   typedef enum logic [1:0]
   {
      OP_PRODUCT = 2'h0,
      OP_ADD = 2'h1,
      OP_SUB = 2'h2,
      OP_ACC = 2'h3
   } op_e;

   localparam int A_W = 19;
   localparam int B_W = 18;
   localparam int ACC_W = 48;
   localparam int SH_W = 4;
   localparam int DUAL_W = 24;
   localparam int QUAD_W = 12;
   // Lane operand widths.
   localparam int D0A_W = 11;
   localparam int D0B_W = 10;
   localparam int D1_W = 8;
   localparam int Q0A_W = 7;
   localparam int Q0B_W = 6;
   localparam int Q1_W = 4;
   // Bit offsets of the lane fields inside the packed A and B operand words.
   localparam int D1_OFS = 11;
   localparam int D1B_OFS = 10;
   localparam int Q_STEP_A = 4;
   localparam int Q1_OFS_A = 7;
   localparam int Q1_OFS_B = 6;
   // BFLOAT16 layout.
   localparam int BF_W = 16;
   localparam int BF_EXP_W = 8;
   localparam int BF_MAN_W = 7;
   localparam logic [7:0] BF_BIAS = 8'h7F;

   // Operands presented by the fabric in one cycle.
   typedef struct packed
   {
      logic [A_W-1:0] a;
      logic [B_W-1:0] b;
      logic [ACC_W-1:0] c;
      logic [SH_W-1:0] shift;
      op_e op;
   } operands_s;

endpackage : mac_pkg

//--- bf16_fma.sv
// BFLOAT16 fused multiply-add: result = acc_i +/- a_i * b_i, product not rounded.
// Assumes normal numbers; zero exponent is flushed to zero, result is truncated.
`timescale 1ns/1ns
module bf16_fma
(
   // Operands.
   input wire logic [15:0] a_i,
   input wire logic [15:0] b_i,
   input wire logic [15:0] acc_i,
   input wire logic sub_i,
   // Result.
   output logic [15:0] y_o
);

   // Full 16-bit significand product, kept exact for the addition.
   wire logic sp = a_i[15] ^ b_i[15] ^ sub_i;
   wire logic za = (a_i[14:7] == 8'h00) || (b_i[14:7] == 8'h00);
   wire logic zc = (acc_i[14:7] == 8'h00);
   wire logic [15:0] prod = 16'({1'h1, a_i[6:0]}) * 16'({1'h1, b_i[6:0]});
   wire logic [9:0] pexp = 10'({2'h0, a_i[14:7]}) + 10'({2'h0, b_i[14:7]})
                           - 10'({2'h0, mac_pkg::BF_BIAS}) + 10'h001;
   wire logic [9:0] cexp = {2'h0, acc_i[14:7]};
   // Aligned magnitudes on a 32-bit field with point below bit 30.
   wire logic [31:0] pm = {1'h0, prod, 15'h0000};
   wire logic [31:0] cm = {1'h0, 1'h1, acc_i[6:0], 23'h000000};
   // Exponents compare signed, since a tiny product's exponent wraps below zero.
   wire logic p_big = za ? 1'h0 : (zc ? 1'h1 : ($signed(pexp) >= $signed(cexp)));
   wire logic [9:0] dexp = p_big ? (pexp - cexp) : (cexp - pexp);
   wire logic [31:0] big_m = p_big ? pm : cm;
   wire logic [31:0] sml_raw = za ? 32'h0 : (p_big ? cm : pm);
   wire logic [31:0] sml_m = (zc && p_big) ? 32'h0 :
                             ((dexp > 10'd31) ? 32'h0 : (sml_raw >> dexp[4:0]));
   wire logic big_s = p_big ? sp : acc_i[15];
   wire logic sml_s = p_big ? acc_i[15] : sp;
   wire logic [9:0] big_e = p_big ? pexp : cexp;
   wire logic same = (big_s == sml_s);
   wire logic ge = big_m >= sml_m;
   wire logic [31:0] mag = same ? (big_m + sml_m) : (ge ? big_m - sml_m : sml_m - big_m);
   wire logic rs = same ? big_s : (ge ? big_s : sml_s);

   // Normalise by finding the leading one.
   logic [4:0] lead;
   logic [31:0] norm;
   logic [9:0] e_out;
   always_comb
   begin
      lead = 5'h00;
      for (int i = 0; i < 32; i++)
      begin
         if (mag[i])
         begin
            lead = 5'(i);
         end
      end
      norm = mag << (5'd31 - lead);
      e_out = big_e + 10'(lead) - 10'd30;
      if (mag == 32'h0 || (za && zc) || e_out[9] || e_out == 10'h000)
      begin
         y_o = 16'h0000;
      end
      else if (e_out >= 10'h0FF)
      begin
         y_o = {rs, 8'hFF, 7'h00};
      end
      else
      begin
         y_o = {rs, e_out[7:0], norm[30:24]};
      end
   end

endmodule : bf16_fma

//--- fabric_source.sv
// Fabric-side operand source feeding the multiply-accumulate block.
// Assumes the bench calls send once per cycle; drives just after the rising edge.
`timescale 1ns/1ns
module fabric_source
(
   // Clock.
   input wire logic ref_clk_i,
   // Operands toward the block.
   output logic valid_o,
   output mac_pkg::operands_s opnd_o
);
   // Idle until the first operation is sent.
   initial
   begin
      valid_o = 1'b0;
      opnd_o = '0;
   end

   // Drives one cycle of operands; idle cycles show inverted stale data.
   task automatic send(input logic go, input mac_pkg::operands_s o);
      @(posedge ref_clk_i);
      #1;
      valid_o = go;
      opnd_o = go ? o : mac_pkg::operands_s'(~opnd_o);
   endtask : send
endmodule : fabric_source

//--- dsp_multiply_accumulate_block_tb_top.sv
// Self-checking bench: one block instance per mode, shared random operands.
// Assumes the block answers one cycle after each taken operand.
`timescale 1ns/1ns
module dsp_multiply_accumulate_block_tb_top;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic valid;
   mac_pkg::operands_s opnd;
   logic [3:0] vld;
   logic [47:0] res [4];
   logic [47:0] exp_r [4];
   logic [31:0] seed = 32'h9C2935F7;
   int miscompares = 0;
   int checked = 0;
   logic [15:0] fa [4] = '{16'h3F80, 16'h4000, 16'h3F80, 16'h4000};
   logic [15:0] fb [4] = '{16'h3F80, 16'h4040, 16'h3F80, 16'h4040};
   logic [15:0] fexp [4] = '{16'h3F80, 16'h40E0, 16'h4100, 16'hC0A0};
   logic [1:0] fop [4] = '{2'h0, 2'h1, 2'h3, 2'h2};

   // one signedness
   // One instance per mode; the dual one runs unsigned, the rest signed.
   for (genvar m = 0; m < 4; m++)
   begin : g_mode
      mac_block #(.MODE(mac_pkg::mode_e'(m)), .SIGNED(m != 1)) dut_u
      (
         .ref_clk_i(ref_clk),
         .resetn_i(resetn),
         .valid_i(valid),
         .opnd_i(opnd),
         .valid_o(vld[m]),
         .result_o(res[m])
      );
   end

   fabric_source src_u (.ref_clk_i(ref_clk), .valid_o(valid), .opnd_o(opnd));

   // Clock generator, 8 ns period.
   initial
   begin
      forever #4 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Takes the low w bits of x, sign or zero extended.
   function automatic longint ext(input longint x, input int w, input bit s);
      longint y;
      y = x << (64 - w);
      return s ? (y >>> (64 - w)) : (y >> (64 - w));
   endfunction : ext

   // Expected integer result of one taken operation, lane by lane.
   function automatic logic [47:0] model(input int m, input logic [47:0] prev,
                                         input mac_pkg::operands_s o);
      int n, aw, bw, ao, bo, rw;
      bit sg;
      longint q, c, p, v;
      logic [47:0] r;
      sg = (m != 1);
      n = (m == 0) ? 1 : 2 * m;
      rw = 48 / n;
      r = '0;
      for (int i = 0; i < n; i++)
      begin
         aw = (m == 0) ? 19 : (m == 1) ? (i > 0 ? 8 : 11) : (i > 0 ? 4 : 7);
         bw = (m == 0) ? 18 : (m == 1) ? (i > 0 ? 8 : 10) : (i > 0 ? 4 : 6);
         ao = (i == 0) ? 0 : (m == 1) ? 11 : 3 + 4 * i;
         bo = (i == 0) ? 0 : (m == 1) ? 10 : 2 + 4 * i;
         q = ext(64'(o.a) >> ao, aw, sg) * ext(64'(o.b) >> bo, bw, sg);
         c = ext(64'(o.c) >> (rw * i), rw, sg);
         p = ext(64'(prev) >> (rw * i), rw, sg);
         v = (o.op == mac_pkg::OP_ADD) ? c + q : (o.op == mac_pkg::OP_SUB) ? c - q :
             (o.op == mac_pkg::OP_ACC) ? p + q : q;
         v = ext(v, rw, sg) >>> o.shift;
         r = r | ((48'(v) & ((48'h1 << rw) - 48'h1)) << (rw * i));
      end
      return r;
   endfunction : model

   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic print_verdict();
      $display("Counts: checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   // Main sequence: float corner cases, saturating operands, then random traffic.
   initial
   begin
      mac_pkg::operands_s o, po;
      logic [127:0] w;
      logic go, pgo;
      pgo = 1'b0;
      po = '0;
      exp_r = '{default: '0};
      repeat (2) @(posedge ref_clk);
      #1 resetn = 1'b1;
      for (int k = 0; k < 604; k++)
      begin
         w = {rnd(), rnd(), rnd(), rnd()};
         o = w[$bits(o)-1:0];
         go = (rnd() % 4) != 0;
         if (k < 4)
         begin
            o = '0;
            o.a = 19'(fa[k]);
            o.b = 18'(fb[k]);
            o.c = 48'h3F80;
            o.op = mac_pkg::op_e'(fop[k]);
            go = 1'b1;
         end
         if (k == 4 || k == 5)
         begin
            o.a = '1;
            o.b = '1;
            o.op = mac_pkg::OP_ACC;
            go = 1'b1;
         end
         src_u.send(go, o);
         for (int m = 0; m < 4; m++)
         begin
            if (pgo && m < 3)
               exp_r[m] = model(m, exp_r[m], po);
            check("valid_o", 48'(vld[m]), 48'(pgo));
            if (m < 3)
               check("result_o", res[m], exp_r[m]);
            else if (k >= 1 && k <= 4)
               check("float result_o", res[3], {32'h0, fexp[k-1]});
         end
         pgo = go;
         po = o;
      end
      print_verdict();
   end

   // Watchdog against a hang, well beyond the expected run time.
   initial
   begin
      #10000;
      miscompares++;
      print_verdict();
   end
endmodule : dsp_multiply_accumulate_block_tb_top
